// ---- verilog/sfq_pkg.sv ----
// Purpose: shared constants for the flash command interpreter
// Assumes: host drives chip select, serial clock and four data lines
// Notes: times in their own unit, cycle counts derived from the clock rate
package sfq_pkg;
  localparam logic [7:0] CMD_SEC_READ = 8'h48;
  localparam logic [7:0] CMD_SET_PARAM = 8'hc0;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [7:0] CMD_QUAD_READ = 8'heb;
  localparam logic [7:0] CMD_WRAP_READ = 8'h0c;
  localparam logic [7:0] CMD_BURST_WRAP = 8'h77;
  localparam logic [7:0] CMD_QUAD_ENTER = 8'h38;
  localparam logic [7:0] CMD_QUAD_EXIT = 8'hff;
  localparam logic [7:0] CMD_RST_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  localparam logic [7:0] SEC_HIGH_BYTE = 8'h00;
  localparam logic [1:0] SEC_LAST_REG = 2'h3;
  localparam logic [9:0] SEC_LAST_BYTE = 10'h3ff;
  localparam logic [9:0] SEC_FIRST_BYTE = 10'h000;
  localparam logic [7:0] ARRAY_ERASED = 8'hff;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam logic [2:0] WRAP_RESET = 3'h7;
  localparam int PARAM_DUMMY_LSB = 4;
  localparam int PARAM_WRAP_LSB = 0;
  localparam int WRAP_BITS_LSB = 4;
  localparam logic [3:0] DUMMY_SHORT = 4'h4;
  localparam logic [3:0] DUMMY_MID = 4'h6;
  localparam logic [3:0] DUMMY_LONG = 4'h8;
  localparam int CLK_MHZ = 25;
  localparam int RST_BUSY_US = 30;
  localparam int RST_BUSY_CYC = RST_BUSY_US * CLK_MHZ;
  localparam int SYNC_STAGES = 2;
endpackage : sfq_pkg

// ---- verilog/sfq_sync.sv ----
// Purpose: two-stage synchroniser for one pin
// Assumes: input asynchronous to clock
// Notes: first stage read only by the second
`timescale 1ns/1ps
module sfq_sync (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic init,
  input wire logic pin,
  output logic syncOut
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign syncOut = sync_q;
  logic unusedInit;
  assign unusedInit = init;
endmodule : sfq_sync

// ---- verilog/sfq_cmd.sv ----
// Purpose: serial flash command interpreter for secure read, parameters, mode and reset
// Assumes: serial clock far slower than clock; sampled, not used as a clock
// Notes: array and secure storage read as erased; program paths live elsewhere
`timescale 1ns/1ps
module sfq_cmd #(
  parameter int RST_CYC = sfq_pkg::RST_BUSY_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic chipSelN,
  input wire logic serialClk,
  input wire logic [3:0] dataIn,
  output logic [3:0] dataOut,
  output logic [3:0] dataOe,
  input wire logic quadModePermit,
  input wire logic writeLatchIn,
  input wire logic suspendIn,
  output logic quadCommandMode,
  output logic [7:0] readParamByte,
  output logic [2:0] wrapSettingBits,
  output logic [7:0] continuousReadBits,
  output logic [3:0] dummyClocks,
  output logic [6:0] wrapLength,
  output logic writeLatch,
  output logic suspendFlag,
  output logic resetBusy,
  output logic [7:0] statusByte
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic csSync;
  logic sckSync;
  logic [3:0] dinSync;
  logic [5:0] pinsIn;
  logic [5:0] pinsOut;
  assign pinsIn = {chipSelN, serialClk, dataIn};
  for (genvar i = 0; i < 6; i++) begin : gSync
    sfq_sync uSync (
      .clock(clock),
      .arst_n(arst_n),
      .init(1'b1),
      .pin(pinsIn[i]),
      .syncOut(pinsOut[i])
    );
  end
  assign csSync = pinsOut[5];
  assign sckSync = pinsOut[4];
  assign dinSync = pinsOut[3:0];

  // ----------------------------------------
  // frame state
  // ----------------------------------------
  typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_PARAM, ST_WRAP, ST_SKIP} sfq_state_t;
  sfq_state_t state_q, state_d;
  logic sckPrev_q, sckPrev_d;
  logic csPrev_q, csPrev_d;
  logic [7:0] shift_q, shift_d;
  logic [4:0] bitCnt_q, bitCnt_d;
  logic [7:0] cmd_q, cmd_d;
  logic [23:0] addr_q, addr_d;
  logic [7:0] outSh_q, outSh_d;
  logic [3:0] dOut_q, dOut_d;
  logic [3:0] dOe_q, dOe_d;
  logic quad_q, quad_d;
  logic [7:0] param_q, param_d;
  logic [2:0] wrapBits_q, wrapBits_d;
  logic [7:0] contRead_q, contRead_d;
  logic wel_q, wel_d;
  logic sus_q, sus_d;
  logic rstArm_q, rstArm_d;
  logic rstArmFrame_q, rstArmFrame_d;
  logic [$clog2(RST_CYC+1)-1:0] rstCnt_q, rstCnt_d;

  logic rise, fall, frameEnd, frameStart;
  logic [4:0] byteBits;
  logic [7:0] inByte;
  logic [3:0] dummyNeed;
  logic [6:0] wrapLen;
  logic [6:0] wrapMask;
  logic [7:0] dataByte;

  assign rise = sckSync && !sckPrev_q;
  assign fall = !sckSync && sckPrev_q;
  assign frameStart = !csSync && csPrev_q;
  assign frameEnd = csSync && !csPrev_q;
  assign byteBits = quad_q ? 5'd2 : 5'd8;
  assign inByte = quad_q ? {shift_q[3:0], dinSync} : {shift_q[6:0], dinSync[0]};

  always_comb begin
    unique case (param_q[sfq_pkg::PARAM_DUMMY_LSB +: 2])
      2'h2: dummyNeed = sfq_pkg::DUMMY_MID;
      2'h3: dummyNeed = sfq_pkg::DUMMY_LONG;
      default: dummyNeed = sfq_pkg::DUMMY_SHORT;
    endcase
    if (quad_q) begin
      wrapLen = 7'(8 << param_q[sfq_pkg::PARAM_WRAP_LSB +: 2]);
    end else begin
      wrapLen = 7'(8 << wrapBits_q[1:0]);
    end
    wrapMask = 7'(wrapLen - 7'd1);
  end

  // erased storage everywhere; secure registers outside 0-3 also erased
  assign dataByte = sfq_pkg::ARRAY_ERASED;

  always_comb begin
    state_d = state_q;
    sckPrev_d = sckSync;
    csPrev_d = csSync;
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    outSh_d = outSh_q;
    dOut_d = dOut_q;
    dOe_d = dOe_q;
    quad_d = quad_q;
    param_d = param_q;
    wrapBits_d = wrapBits_q;
    contRead_d = contRead_q;
    wel_d = writeLatchIn;
    sus_d = suspendIn;
    rstArm_d = rstArm_q;
    rstArmFrame_d = rstArmFrame_q;
    rstCnt_d = (rstCnt_q != '0) ? rstCnt_q - 1'b1 : rstCnt_q;
    if (frameStart) begin
      state_d = (rstCnt_q != '0) ? ST_SKIP : ST_CMD;
      bitCnt_d = '0;
      // stale opcode must not act again in a frame with no clocks
      cmd_d = 8'h00;
      rstArmFrame_d = rstArm_q;
      rstArm_d = 1'b0;
    end else if (frameEnd) begin
      dOe_d = 4'h0;
      if (state_q == ST_CMD && bitCnt_q == 5'd0) begin
        unique case (cmd_q)
          sfq_pkg::CMD_QUAD_ENTER: if (quadModePermit) quad_d = 1'b1;
          sfq_pkg::CMD_QUAD_EXIT: quad_d = 1'b0;
          sfq_pkg::CMD_RST_ENABLE: rstArm_d = 1'b1;
          sfq_pkg::CMD_RST: if (rstArmFrame_q) begin
            quad_d = 1'b0;
            param_d = sfq_pkg::PARAM_RESET;
            wrapBits_d = sfq_pkg::WRAP_RESET;
            contRead_d = 8'h00;
            wel_d = 1'b0;
            sus_d = 1'b0;
            rstCnt_d = ($clog2(RST_CYC+1))'(RST_CYC);
          end
          default: ;
        endcase
      end
      state_d = ST_IDLE;
    end else if (rise && state_q != ST_IDLE && state_q != ST_SKIP) begin
      shift_d = inByte;
      bitCnt_d = bitCnt_q + 5'h01;
      unique case (state_q)
        ST_CMD: if (bitCnt_q + 5'd1 == byteBits) begin
          cmd_d = inByte;
          bitCnt_d = '0;
          if (inByte == sfq_pkg::CMD_SEC_READ || inByte == sfq_pkg::CMD_FAST_READ ||
              inByte == sfq_pkg::CMD_QUAD_READ || inByte == sfq_pkg::CMD_WRAP_READ) begin
            state_d = ST_ADDR;
          end else if (inByte == sfq_pkg::CMD_SET_PARAM && quad_q) begin
            state_d = ST_PARAM;
          end else if (inByte == sfq_pkg::CMD_BURST_WRAP) begin
            state_d = ST_WRAP;
          end
          // bitCnt stays 0: a full opcode, acted on at frame end
        end else if (bitCnt_q + 5'd1 < byteBits) begin
        end
        ST_ADDR: if (bitCnt_q + 5'd1 == 5'(3 * byteBits)) begin
          addr_d = {addr_q[15:0], inByte};
          bitCnt_d = '0;
          state_d = ST_DUMMY;
        end else if ((bitCnt_q + 5'd1) % byteBits == 5'd0) begin
          addr_d = {addr_q[15:0], inByte};
        end
        ST_DUMMY: if (bitCnt_q + 5'd1 == ((cmd_q == sfq_pkg::CMD_SEC_READ || !quad_q) ? 5'd8 : 5'(dummyNeed))) begin
          bitCnt_d = '0;
          state_d = ST_DATA;
          outSh_d = dataByte;
        end
        ST_PARAM, ST_WRAP: if (bitCnt_q + 5'd1 == byteBits) begin
          bitCnt_d = '0;
          if (state_q == ST_PARAM) param_d = inByte;
          else wrapBits_d = inByte[sfq_pkg::WRAP_BITS_LSB +: 3];
          state_d = ST_SKIP;
        end
        default: bitCnt_d = bitCnt_q;
      endcase
    end else if (fall && state_q == ST_DATA) begin
      dOe_d = quad_q ? 4'hf : 4'h2;
      dOut_d = quad_q ? outSh_q[7:4] : {2'b00, outSh_q[7], 1'b0};
      outSh_d = quad_q ? {outSh_q[3:0], 4'h0} : {outSh_q[6:0], 1'b0};
      if (bitCnt_q + 5'd1 == byteBits) begin
        bitCnt_d = '0;
        outSh_d = dataByte;
        if (cmd_q == sfq_pkg::CMD_SEC_READ) begin
          addr_d[9:0] = (addr_q[9:0] == sfq_pkg::SEC_LAST_BYTE) ? sfq_pkg::SEC_FIRST_BYTE : addr_q[9:0] + 10'd1;
        end else if (cmd_q == sfq_pkg::CMD_WRAP_READ && quad_q) begin
          addr_d[6:0] = (addr_q[6:0] & ~wrapMask) | ((addr_q[6:0] + 7'd1) & wrapMask);
        end else begin
          addr_d = addr_q + 24'd1;
        end
      end else begin
        bitCnt_d = bitCnt_q + 5'd1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      // matches the synchroniser reset level, so no false edge after reset
      sckPrev_q <= 1'b1;
      csPrev_q <= 1'b1;
      shift_q <= 8'h00;
      bitCnt_q <= '0;
      cmd_q <= 8'h00;
      addr_q <= 24'h000000;
      outSh_q <= 8'h00;
      dOut_q <= 4'h0;
      dOe_q <= 4'h0;
      quad_q <= 1'b0;
      param_q <= sfq_pkg::PARAM_RESET;
      wrapBits_q <= sfq_pkg::WRAP_RESET;
      contRead_q <= 8'h00;
      wel_q <= 1'b0;
      sus_q <= 1'b0;
      rstArm_q <= 1'b0;
      rstArmFrame_q <= 1'b0;
      rstCnt_q <= '0;
    end else begin
      state_q <= state_d;
      sckPrev_q <= sckPrev_d;
      csPrev_q <= csPrev_d;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      outSh_q <= outSh_d;
      dOut_q <= dOut_d;
      dOe_q <= dOe_d;
      quad_q <= quad_d;
      param_q <= param_d;
      wrapBits_q <= wrapBits_d;
      contRead_q <= contRead_d;
      wel_q <= wel_d;
      sus_q <= sus_d;
      rstArm_q <= rstArm_d;
      rstArmFrame_q <= rstArmFrame_d;
      rstCnt_q <= rstCnt_d;
    end
  end

  assign dataOut = dOut_q;
  assign dataOe = dOe_q;
  assign quadCommandMode = quad_q;
  assign readParamByte = param_q;
  assign wrapSettingBits = wrapBits_q;
  assign continuousReadBits = contRead_q;
  assign dummyClocks = dummyNeed;
  assign wrapLength = wrapLen;
  assign writeLatch = wel_q;
  assign suspendFlag = sus_q;
  assign resetBusy = rstCnt_q != '0;
  assign statusByte = sfq_pkg::STATUS_RESET;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_quad_permit: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(quad_q) |-> quadModePermit) else $error("quad mode entered without permit");
  chk_rst_busy: assert property (@(posedge clock) disable iff (!arst_n)
    resetBusy && frameStart |=> state_q == ST_SKIP) else $error("command taken while reset busy");
  sequence sRstTaken;
    $rose(resetBusy);
  endsequence
  chk_rst_clear: assert property (@(posedge clock) disable iff (!arst_n)
    sRstTaken |-> !quad_q && param_q == sfq_pkg::PARAM_RESET) else $error("reset left state");
  chk_rst_pair: assert property (@(posedge clock) disable iff (!arst_n)
    sRstTaken |-> $past(rstArmFrame_q)) else $error("reset without enable frame");
  chk_out_fall: assert property (@(posedge clock) disable iff (!arst_n)
    $changed(dOut_q) |-> $past(fall) || $past(frameEnd)) else $error("output changed off falling edge");
  chk_sec_wrap: assert property (@(posedge clock) disable iff (!arst_n)
    state_q == ST_DATA && cmd_q == sfq_pkg::CMD_SEC_READ |->
      addr_q[23:10] == $past(addr_q[23:10]) || $past(state_q) != ST_DATA)
    else $error("secure address left register");
  chk_wrap_window: assert property (@(posedge clock) disable iff (!arst_n)
    state_q == ST_DATA && $past(state_q) == ST_DATA && cmd_q == sfq_pkg::CMD_WRAP_READ && quad_q |->
      addr_q[23:7] == $past(addr_q[23:7]) && (addr_q[6:0] & ~wrapMask) == ($past(addr_q[6:0]) & ~wrapMask))
    else $error("wrapped read left its window");
  chk_param_quad: assert property (@(posedge clock) disable iff (!arst_n)
    $changed(param_q) && !$rose(resetBusy) |-> $past(quad_q)) else $error("parameters set outside quad mode");
  chk_dummy_map: assert property (@(posedge clock) disable iff (!arst_n)
    param_q[5:4] == 2'h3 |-> dummyNeed == 4'h8) else $error("dummy count wrong");
endmodule : sfq_cmd

// ---- test/sfq_host_model.sv ----
// Purpose: host controller model driving the flash pins
// Assumes: serial clock idles low between frames
// Notes: released data lines toggle so no stale level is read back
`timescale 1ns/1ps
module sfq_host_model (
  output logic chipSelN,
  output logic serialClk,
  output logic [3:0] dataIn,
  input wire logic [3:0] dataOut,
  input wire logic [3:0] dataOe
);
  int halfNs = 160;
  initial begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
    dataIn = 4'h0;
  end
  // ------------------
  // frame tasks
  // ------------------
  task automatic frameStart();
    chipSelN = 1'b0;
    #(halfNs);
  endtask : frameStart
  // each frame stands alone, so a reset pair is two of these
  task automatic frameEnd();
    #(halfNs);
    chipSelN = 1'b1;
    dataIn = ~dataIn;
    #(halfNs * 3);
  endtask : frameEnd
  // data moves while the clock is low; sampled late, as output holds to the fall
  task automatic xfer(input logic [7:0] tx, input int clks, input bit quad, input bit drv,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int k = 0; k < clks; k++) begin
      if (!drv) dataIn = ~dataIn;
      else if (quad) dataIn = tx[7 - 4 * k -: 4];
      else dataIn = {~dataIn[3:1], tx[7 - k]};
      #(halfNs);
      serialClk = 1'b1;
      #(halfNs - 2);
      // an undriven lane reads back inverted, so a dropped enable shows up
      rx = quad ? {rx[3:0], dataOut ^ ~dataOe} : {rx[6:0], dataOut[1] ^ ~dataOe[1]};
      #2;
      serialClk = 1'b0;
    end
  endtask : xfer
endmodule : sfq_host_model

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the flash command interpreter
// Assumes: reset busy shortened to 20 clocks
// Notes: storage reads erased, so read data is always ff
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic quadModePermit = 1'b0;
  logic writeLatchIn = 1'b0;
  logic suspendIn = 1'b0;
  logic chipSelN, serialClk, quadCommandMode, writeLatch, suspendFlag, resetBusy, w, s;
  logic [3:0] dataIn, dataOut, dataOe, dummyClocks;
  logic [7:0] readParamByte, continuousReadBits, statusByte, rx, par, wrapByte;
  logic [2:0] wrapSettingBits;
  logic [6:0] wrapLength;
  int error_cnt = 0;
  int total_checks = 0;
  always #20 clock = ~clock;
  sfq_cmd #(.RST_CYC(20)) dut (.clock(clock), .arst_n(arst_n), .chipSelN(chipSelN),
    .serialClk(serialClk), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .quadModePermit(quadModePermit), .writeLatchIn(writeLatchIn), .suspendIn(suspendIn),
    .quadCommandMode(quadCommandMode), .readParamByte(readParamByte), .wrapSettingBits(wrapSettingBits),
    .continuousReadBits(continuousReadBits), .dummyClocks(dummyClocks), .wrapLength(wrapLength),
    .writeLatch(writeLatch), .suspendFlag(suspendFlag), .resetBusy(resetBusy), .statusByte(statusByte));
  sfq_host_model host (.chipSelN(chipSelN), .serialClk(serialClk), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe));
  // ------------------
  // helpers
  // ------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] dummyFor(input logic [1:0] c);
    return (c == 2'h3) ? 8'h08 : ((c == 2'h2) ? 8'h06 : 8'h04);
  endfunction : dummyFor
  task automatic cmd(input logic [7:0] op, input bit quad);
    host.frameStart();
    host.xfer(op, quad ? 2 : 8, quad, 1'b1, rx);
    host.frameEnd();
  endtask : cmd
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    results();
  end
  // ------------------
  // main sequence
  // ------------------
  initial begin
    void'($urandom(32'h0d52));
    repeat (4) @(posedge clock);
    @(negedge clock) arst_n = 1'b1;
    repeat (4) @(negedge clock);
    chk(readParamByte, sfq_pkg::PARAM_RESET);
    chk({5'h00, wrapSettingBits}, {5'h00, sfq_pkg::WRAP_RESET});
    chk({2'h0, quadCommandMode, resetBusy, dataOe}, 8'h00);
    chk(statusByte, sfq_pkg::STATUS_RESET);
    chk(continuousReadBits, 8'h00);
    host.frameStart();
    host.xfer(sfq_pkg::CMD_SEC_READ, 8, 0, 1, rx);
    host.xfer(sfq_pkg::SEC_HIGH_BYTE, 8, 0, 1, rx);
    host.xfer({2'h0, 2'($urandom_range(3)), 4'h0}, 8, 0, 1, rx);
    host.xfer(8'hfe, 8, 0, 1, rx);
    host.xfer(8'h00, 8, 0, 0, rx);
    repeat (3) begin
      host.xfer(8'h00, 8, 0, 0, rx);
      chk(rx, sfq_pkg::ARRAY_ERASED);
    end
    chk({4'h0, dataOe}, 8'h02);
    host.frameEnd();
    chk({4'h0, dataOe}, 8'h00);
    // parameter write outside quad mode is dropped
    host.frameStart();
    host.xfer(sfq_pkg::CMD_SET_PARAM, 8, 0, 1, rx);
    host.xfer(8'h30, 8, 0, 1, rx);
    host.frameEnd();
    chk(readParamByte, 8'h00);
    // slow host; same byte repeated so the data byte lands whatever its slot
    wrapByte = 8'($urandom);
    host.halfNs = 320;
    host.frameStart();
    host.xfer(sfq_pkg::CMD_BURST_WRAP, 8, 0, 1, rx);
    repeat (4) host.xfer(wrapByte, 8, 0, 1, rx);
    host.frameEnd();
    host.halfNs = 160;
    chk({5'h00, wrapSettingBits}, {5'h00, wrapByte[6:4]});
    chk({1'b0, wrapLength}, 8'h08 << wrapByte[5:4]);
    @(negedge clock);
    w = 1'($urandom);
    s = 1'($urandom);
    writeLatchIn = w;
    suspendIn = s;
    cmd(sfq_pkg::CMD_QUAD_ENTER, 0);
    chk({7'h00, quadCommandMode}, 8'h00);
    @(negedge clock) quadModePermit = 1'b1;
    cmd(sfq_pkg::CMD_QUAD_ENTER, 0);
    chk({7'h00, quadCommandMode}, 8'h01);
    chk({6'h00, writeLatch, suspendFlag}, {6'h00, w, s});
    chk({5'h00, wrapSettingBits}, {5'h00, wrapByte[6:4]});
    for (int c = 0; c < 4; c++) begin
      par = {2'h0, 2'(c), 2'($urandom), 2'(3 - c)};
      host.frameStart();
      host.xfer(sfq_pkg::CMD_SET_PARAM, 2, 1, 1, rx);
      host.xfer(par, 2, 1, 1, rx);
      host.frameEnd();
      chk(readParamByte, par);
      chk({4'h0, dummyClocks}, dummyFor(par[5:4]));
      chk({1'b0, wrapLength}, 8'h08 << par[1:0]);
      host.frameStart();
      host.xfer(sfq_pkg::CMD_WRAP_READ, 2, 1, 1, rx);
      repeat (3) host.xfer(8'($urandom), 2, 1, 1, rx);
      host.xfer(8'h00, int'(dummyFor(par[5:4])), 1, 0, rx);
      repeat (2) begin
        host.xfer(8'h00, 2, 1, 0, rx);
        chk(rx, sfq_pkg::ARRAY_ERASED);
      end
      chk({4'h0, dataOe}, 8'h0f);
      host.frameEnd();
    end
    // cut reset frame between enable and reset cancels the pair
    cmd(sfq_pkg::CMD_RST_ENABLE, 1);
    host.frameStart();
    host.xfer(sfq_pkg::CMD_RST, 1, 1, 1, rx);
    host.frameEnd();
    cmd(sfq_pkg::CMD_RST, 1);
    chk(readParamByte, par);
    chk({7'h00, resetBusy}, 8'h00);
    cmd(sfq_pkg::CMD_RST_ENABLE, 1);
    cmd(sfq_pkg::CMD_RST, 1);
    chk({7'h00, resetBusy}, 8'h01);
    chk(readParamByte, sfq_pkg::PARAM_RESET);
    chk({4'h0, wrapSettingBits, quadCommandMode}, {4'h0, sfq_pkg::WRAP_RESET, 1'b0});
    cmd(sfq_pkg::CMD_QUAD_ENTER, 0);
    chk({7'h00, quadCommandMode}, 8'h00);
    repeat (24) @(negedge clock);
    cmd(sfq_pkg::CMD_QUAD_ENTER, 0);
    chk({7'h00, quadCommandMode}, 8'h01);
    cmd(sfq_pkg::CMD_QUAD_EXIT, 1);
    chk({7'h00, quadCommandMode}, 8'h00);
    chk({6'h00, writeLatch, suspendFlag}, {6'h00, w, s});
    results();
  end
endmodule : testbench
